// ---- rtl/ebs_pkg.sv ----
// Purpose: Shared types and constants for the expansion bus select/data lane block
// Assumes: Eight chip selects, 32-bit data path, four byte lanes
// Notes: Phase lengths are counted in link clock cycles
package ebs_pkg;

  localparam int unsigned EBS_NUM_CS = 8;
  localparam int unsigned EBS_DATA_W = 32;
  localparam int unsigned EBS_LANES = 4;
  // Lowest chip select that may run host port cycles
  localparam logic [2:0] EBS_HOSTPORT_MIN_CS = 3'h4;

  // Reset values of the pins
  localparam logic [7:0] EBS_CS_IDLE = 8'hFF;
  localparam logic [3:0] EBS_BE_IDLE = 4'hF;

  // Cycle styles a chip select may be set to
  typedef enum logic [2:0] {
    EBS_MODE_STROBE,
    EBS_MODE_BURST,
    EBS_MODE_DSTROBE,
    EBS_MODE_NOTURN,
    EBS_MODE_HOSTPORT
  } ebs_mode_t;

  // Link cycles the chip select stays low, per style
  localparam logic [2:0] EBS_LEN_STROBE = 3'h3;
  localparam logic [2:0] EBS_LEN_BURST = 3'h1;
  localparam logic [2:0] EBS_LEN_DSTROBE = 3'h2;
  localparam logic [2:0] EBS_LEN_NOTURN = 3'h1;
  localparam logic [2:0] EBS_LEN_HOSTPORT = 3'h4;

  // One outbound request, carried across the clock crossing as a whole
  typedef struct packed {
    logic write;
    logic [2:0] cs;
    ebs_mode_t mode;
    logic [3:0] be;
    logic [31:0] wdata;
  } ebs_req_t;

endpackage : ebs_pkg

// ---- rtl/ebs_word_mem.sv ----
// Purpose: Inbound target word store with byte lane writes
// Assumes: Single clock, one write or read port per cycle
// Notes: Read data come out of a register, one cycle after the address
`timescale 1ns/1ps
module ebs_word_mem
  import ebs_pkg::*;
#(
  parameter int unsigned DEPTH = 16,
  parameter int unsigned AW = $clog2(DEPTH)
)
(
  // Clock
  input wire logic clk,
  // Write side
  input wire logic wr_en,
  input wire logic [3:0] wr_lanes,
  input wire logic [AW-1:0] addr,
  input wire logic [31:0] wr_data,
  // Read side
  output logic [31:0] rd_data
);

  wire [31:0] rd_word;

  // Refuse a depth that the address cannot reach
  if (DEPTH < 2 || (1 << AW) < DEPTH)
  begin : g_bad_depth
    $error("ebs_word_mem: DEPTH and AW do not fit");
  end

  ////////////////////////////////////////////////////////////////////////////
  // One store per lane, so each has a single writer and others keep their byte
  for (genvar g = 0; g < 4; g++)
  begin : g_lane
    logic [7:0] lane_q [DEPTH];

    always_ff @(posedge clk)
    begin
      if (wr_en && wr_lanes[g])
        lane_q[addr] <= wr_data[8*g +: 8];
    end

    assign rd_word[8*g +: 8] = lane_q[addr];
  end

  // Registered read port; always a whole word
  always_ff @(posedge clk)
  begin
    rd_data <= rd_word;
  end

endmodule : ebs_word_mem

// ---- rtl/ebs_lanes.sv ----
// Purpose: Chip select, data and byte lane pins of the expansion bus
// Assumes: Internal requests on clk_sys, pins on expansion_bus_clock
// Notes: Pins are split into input, output and output enable
`timescale 1ns/1ps

// Function
// - Assert addressed chip select for outbound cycles
// - Any select: strobe, burst, data-strobe, no-turnaround
// - Host port cycles only on selects four-seven
// - Arbiter samples chip selects for idle
// - Driven selects reach only the arbiter
// - 32-bit data, direction by transfer
// - Active-low byte lanes mark outbound bytes
// - Inbound writes update only enabled bytes
// - Byte lanes released while master granted
// - Pins sampled and launched on bus clock
module ebs_lanes
  import ebs_pkg::*;
#(
  parameter int unsigned MEM_DEPTH = 16,
  parameter int unsigned AW = $clog2(MEM_DEPTH)
)
(
  // System side
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire ebs_mode_t cs_mode [EBS_NUM_CS],
  input wire logic req_valid,
  input wire ebs_req_t req_in,
  output logic req_ready,
  output logic rsp_valid,
  output logic rsp_err,
  output logic [31:0] rsp_rdata,
  // Link clock and arbiter
  input wire logic expansion_bus_clock,
  input wire logic ext_grant,
  output logic arb_cs_idle,
  // Chip select pins
  input wire logic [7:0] bus_chip_selects_i,
  output logic [7:0] bus_chip_selects_o,
  output logic bus_chip_selects_oe,
  // Data pins
  input wire logic [31:0] bus_data_lines_i,
  output logic [31:0] bus_data_lines_o,
  output logic bus_data_lines_oe,
  // Byte lane pins
  input wire logic [3:0] byte_lane_selects_i,
  output logic [3:0] byte_lane_selects_o,
  output logic byte_lane_selects_oe,
  // Inbound strobes from a granted master
  input wire logic [AW-1:0] in_addr,
  input wire logic in_wr_n,
  input wire logic in_rd_n
);

  // Refuse a store too small to address
  if (MEM_DEPTH < 2)
  begin : g_bad_depth
    $error("ebs_lanes: MEM_DEPTH too small");
  end

  ////////////////////////////////////////////////////////////////////////////
  // System domain: accept, hold and answer requests
  ebs_req_t req_q;
  logic busy_q;
  logic req_tgl_q;
  logic [2:0] ack_sync_q;
  logic [31:0] link_rdata_q;
  logic ack_tgl_q;
  ebs_mode_t sel_mode;
  logic mode_bad;

  // Mode comes from the per-select setting; host port below four is refused
  assign sel_mode = cs_mode[req_in.cs];
  assign mode_bad = (sel_mode == EBS_MODE_HOSTPORT) && (req_in.cs < EBS_HOSTPORT_MIN_CS);

  // Request is held stable while busy so the link reads it directly
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      req_q <= '0;
      busy_q <= 1'b0;
      req_tgl_q <= 1'b0;
    end
    else if (req_valid && req_ready && !mode_bad)
    begin
      req_q <= req_in;
      req_q.mode <= sel_mode;
      busy_q <= 1'b1;
      req_tgl_q <= ~req_tgl_q;
    end
    else if (ack_sync_q[2] != ack_sync_q[1])
      busy_q <= 1'b0;
  end

  // Ack toggle synchroniser; first stage feeds only the second
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
      ack_sync_q <= 3'h0;
    else
      ack_sync_q <= {ack_sync_q[1], ack_sync_q[0], ack_tgl_q};
  end

  // Answers: refused modes answer at once, bus cycles on ack edge
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      rsp_valid <= 1'b0;
      rsp_err <= 1'b0;
      rsp_rdata <= 32'h0000_0000;
    end
    else
    begin
      rsp_valid <= 1'b0;
      rsp_err <= 1'b0;
      if (req_valid && req_ready && mode_bad)
      begin
        rsp_valid <= 1'b1;
        rsp_err <= 1'b1;
      end
      else if (busy_q && (ack_sync_q[2] != ack_sync_q[1]))
      begin
        rsp_valid <= 1'b1;
        rsp_rdata <= link_rdata_q;
      end
    end
  end

  // Ready is registered; low while a request is in flight
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
      req_ready <= 1'b0;
    else
      req_ready <= !busy_q && !(req_valid && req_ready && !mode_bad);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: reset and request toggle crossing
  logic [1:0] lrst_q;
  logic lrst_b;
  logic [2:0] req_sync_q;
  logic [1:0] cs_idle_sync_q;
  logic new_req;

  always_ff @(posedge expansion_bus_clock)
  begin
    lrst_q <= {lrst_q[0], rst_b};
  end
  assign lrst_b = lrst_q[1];

  always_ff @(posedge expansion_bus_clock)
  begin
    if (!lrst_b)
      req_sync_q <= 3'h0;
    else
      req_sync_q <= {req_sync_q[1], req_sync_q[0], req_tgl_q};
  end
  assign new_req = req_sync_q[2] != req_sync_q[1];

  // Select lines feed the arbiter idle flag and nothing else
  always_ff @(posedge expansion_bus_clock)
  begin
    if (!lrst_b)
    begin
      cs_idle_sync_q <= 2'h0;
      arb_cs_idle <= 1'b0;
    end
    else
    begin
      cs_idle_sync_q <= {cs_idle_sync_q[0], &bus_chip_selects_i};
      arb_cs_idle <= cs_idle_sync_q[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outbound cycle machine
  typedef enum logic [1:0] {
    EBS_L_IDLE,
    EBS_L_DATA,
    EBS_L_WAIT
  } ebs_lstate_t;

  ebs_lstate_t lst_q;
  logic [2:0] cnt_q;
  logic [2:0] phase_len;

  always_comb
  begin
    case (req_q.mode)
      EBS_MODE_STROBE: phase_len = EBS_LEN_STROBE;
      EBS_MODE_BURST: phase_len = EBS_LEN_BURST;
      EBS_MODE_DSTROBE: phase_len = EBS_LEN_DSTROBE;
      EBS_MODE_NOTURN: phase_len = EBS_LEN_NOTURN;
      EBS_MODE_HOSTPORT: phase_len = EBS_LEN_HOSTPORT;
      default: phase_len = EBS_LEN_STROBE;
    endcase
  end

  // Pending requests wait in WAIT while a master holds the grant
  always_ff @(posedge expansion_bus_clock)
  begin
    if (!lrst_b)
    begin
      lst_q <= EBS_L_IDLE;
      cnt_q <= 3'h0;
      ack_tgl_q <= 1'b0;
      link_rdata_q <= 32'h0000_0000;
    end
    else
    begin
      case (lst_q)
        EBS_L_IDLE:
          if (new_req)
            lst_q <= EBS_L_WAIT;
        EBS_L_WAIT:
          if (!ext_grant)
          begin
            lst_q <= EBS_L_DATA;
            cnt_q <= phase_len - 3'h1;
          end
        EBS_L_DATA:
          if (cnt_q == 3'h0)
          begin
            if (!req_q.write)
              link_rdata_q <= bus_data_lines_i;
            ack_tgl_q <= ~ack_tgl_q;
            lst_q <= EBS_L_IDLE;
          end
          else
            cnt_q <= cnt_q - 3'h1;
        default:
          lst_q <= EBS_L_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Inbound target store
  logic [31:0] mem_rdata;
  logic in_wr;
  logic in_rd_q;

  assign in_wr = ext_grant && !in_wr_n;

  ebs_word_mem #(
    .DEPTH(MEM_DEPTH),
    .AW(AW)
  ) u_mem (
    .clk(expansion_bus_clock),
    .wr_en(in_wr),
    .wr_lanes(~byte_lane_selects_i),
    .addr(in_addr),
    .wr_data(bus_data_lines_i),
    .rd_data(mem_rdata)
  );

  always_ff @(posedge expansion_bus_clock)
  begin
    if (!lrst_b)
      in_rd_q <= 1'b0;
    else
      in_rd_q <= ext_grant && !in_rd_n;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers, all from flops on the link clock
  logic out_active;
  assign out_active = (lst_q == EBS_L_WAIT) && !ext_grant;

  always_ff @(posedge expansion_bus_clock)
  begin
    if (!lrst_b)
    begin
      bus_chip_selects_o <= EBS_CS_IDLE;
      bus_chip_selects_oe <= 1'b0;
      byte_lane_selects_o <= EBS_BE_IDLE;
      byte_lane_selects_oe <= 1'b0;
    end
    else
    begin
      bus_chip_selects_oe <= !ext_grant;
      byte_lane_selects_oe <= !ext_grant;
      if (out_active)
      begin
        bus_chip_selects_o <= ~(8'h01 << req_q.cs);
        byte_lane_selects_o <= ~req_q.be;
      end
      else if (lst_q == EBS_L_IDLE || (lst_q == EBS_L_DATA && cnt_q == 3'h0))
      begin
        bus_chip_selects_o <= EBS_CS_IDLE;
        byte_lane_selects_o <= EBS_BE_IDLE;
      end
    end
  end

  // Data driven for outbound writes and granted inbound reads only
  always_ff @(posedge expansion_bus_clock)
  begin
    if (!lrst_b)
    begin
      bus_data_lines_o <= 32'h0000_0000;
      bus_data_lines_oe <= 1'b0;
    end
    else if (out_active && req_q.write)
    begin
      bus_data_lines_o <= req_q.wdata;
      bus_data_lines_oe <= 1'b1;
    end
    else if (in_rd_q && ext_grant)
    begin
      bus_data_lines_o <= mem_rdata;
      bus_data_lines_oe <= 1'b1;
    end
    else if (!(lst_q == EBS_L_DATA && cnt_q != 3'h0 && req_q.write))
      bus_data_lines_oe <= 1'b0;
  end

endmodule : ebs_lanes

// ---- sim/ebs_lanes_asserts.sv ----
// Purpose: Pin and handshake checks for ebs_lanes
// Assumes: Bound to the top ports
// Notes: Link checks run on the link clock
`timescale 1ns/1ps
module ebs_lanes_asserts
  import ebs_pkg::*;
(
  // Clocks and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic expansion_bus_clock,
  // System side
  input wire ebs_mode_t cs_mode [EBS_NUM_CS],
  input wire logic req_valid,
  input wire ebs_req_t req_in,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic rsp_err,
  // Link side
  input wire logic ext_grant,
  input wire logic arb_cs_idle,
  input wire logic [7:0] bus_chip_selects_i,
  input wire logic [7:0] bus_chip_selects_o,
  input wire logic bus_chip_selects_oe,
  input wire logic bus_data_lines_oe,
  input wire logic byte_lane_selects_oe
);
  // A select leaving idle opens one bus phase
  sequence s_sel_start;
    $fell(&bus_chip_selects_o);
  endsequence
  sequence s_sel_done;
    ##[1:4] (&bus_chip_selects_o);
  endsequence
  a_sel_onehot: assert property (
    @(posedge expansion_bus_clock) disable iff (!rst_b)
    (bus_chip_selects_o != EBS_CS_IDLE) |-> $onehot(~bus_chip_selects_o)) else $error("select not one-hot");
  a_sel_bounded: assert property (
    @(posedge expansion_bus_clock) disable iff (!rst_b) s_sel_start |-> s_sel_done) else $error("select too long");
  a_sel_driven: assert property (
    @(posedge expansion_bus_clock) disable iff (!rst_b)
    (bus_chip_selects_o != EBS_CS_IDLE) |-> bus_chip_selects_oe) else $error("select low undriven");
  a_grant_release: assert property (
    @(posedge expansion_bus_clock) disable iff (!rst_b)
    ext_grant [*3] |-> !byte_lane_selects_oe && !bus_chip_selects_oe) else $error("lanes kept in grant");
  a_idle_seen: assert property (
    @(posedge expansion_bus_clock) disable iff (!rst_b)
    (&bus_chip_selects_i) [*8] |-> arb_cs_idle) else $error("idle missed");
  a_busy_seen: assert property (
    @(posedge expansion_bus_clock) disable iff (!rst_b)
    (!(&bus_chip_selects_i)) [*4] |-> !arb_cs_idle) else $error("busy missed");
  a_hostport_err: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    req_valid && req_ready && req_in.cs < EBS_HOSTPORT_MIN_CS && cs_mode[req_in.cs] == EBS_MODE_HOSTPORT
    |=> rsp_valid && rsp_err) else $error("host port not refused");
  a_high_ok: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    req_valid && req_ready && req_in.cs >= EBS_HOSTPORT_MIN_CS |-> ##[1:100] (rsp_valid && !rsp_err))
    else $error("upper select refused");
  a_write_lanes: assert property (
    @(posedge expansion_bus_clock) disable iff (!rst_b)
    bus_data_lines_oe && !ext_grant |-> byte_lane_selects_oe) else $error("lanes not driven");
endmodule : ebs_lanes_asserts

// ---- sim/ebs_far_model.sv ----
// Purpose: Board, devices and master stand-in at the pins
// Assumes: Select lines pulled up on the board
// Notes: Undriven data toggles so stale values never pass
`timescale 1ns/1ps
module ebs_far_model
  import ebs_pkg::*;
#(
  parameter logic [31:0] RD_BASE = 32'h5A3C_0000
)
(
  // Link clock
  input wire logic clk,
  // Device pins
  input wire logic [7:0] cs_o,
  input wire logic cs_oe,
  input wire logic [31:0] d_o,
  input wire logic d_oe,
  input wire logic [3:0] be_o,
  input wire logic be_oe,
  // Master stand-in
  input wire logic [7:0] m_cs,
  input wire logic m_den,
  input wire logic [31:0] m_d,
  input wire logic [3:0] m_be,
  // Resolved wires
  output logic [7:0] cs_i,
  output logic [31:0] d_i,
  output logic [3:0] be_i
);
  logic [31:0] last_q;
  logic [2:0] sel;
  // Master holds FF when idle, like the pull-ups
  assign cs_i = cs_oe ? cs_o : m_cs;
  assign be_i = be_oe ? be_o : m_be;
  // Index of the selected device
  always_comb
  begin
    sel = 3'h0;
    for (int i = 0; i < 8; i++)
      if (!cs_o[i])
        sel = 3'(i);
  end
  // Selected device answers a read at once
  assign d_i = d_oe ? d_o : m_den ? m_d : (cs_oe && cs_o != EBS_CS_IDLE) ? (RD_BASE ^ {29'h0, sel}) : ~last_q;
  always_ff @(posedge clk)
    last_q <= d_i;
endmodule : ebs_far_model

// ---- sim/ebs_lanes_test.sv ----
// Purpose: Self-checking bench for ebs_lanes
// Assumes: Far side from ebs_far_model
// Notes: Seed 95, link clock 6 ns
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin failures++; $display("Error %0t: got %h want %h", $time, g, e); end end
module ebs_lanes_test
  import ebs_pkg::*;
;
  logic clk_sys = 0, lclk = 0, rst_b = 0, req_valid = 0, ext_grant = 0, in_wr_n = 1, in_rd_n = 1, m_den = 0;
  ebs_mode_t cs_mode [EBS_NUM_CS] = '{default: EBS_MODE_STROBE};
  ebs_req_t req_in = '0;
  logic [7:0] m_cs = 8'hFF, a_cs, cs_i, cs_o;
  logic [31:0] m_d = '0, a_dat, d_i, d_o, rsp_rdata;
  logic [31:0] mem [16];
  logic [3:0] m_be = 4'hF, in_addr = '0, a_be, be_i, be_o;
  logic req_ready, rsp_valid, rsp_err, arb_cs_idle, cs_oe, d_oe, be_oe, a_we;
  int failures = 0, total_checks = 0, act_n = 0;
  always #5 clk_sys = ~clk_sys;
  // Link clock offset so the two edges never line up
  initial
  begin
    #1.3;
    forever #3 lclk = ~lclk;
  end
  ebs_lanes dut (.clk_sys(clk_sys), .rst_b(rst_b), .cs_mode(cs_mode), .req_valid(req_valid), .req_in(req_in),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_err(rsp_err), .rsp_rdata(rsp_rdata),
    .expansion_bus_clock(lclk), .ext_grant(ext_grant), .arb_cs_idle(arb_cs_idle), .bus_chip_selects_i(cs_i),
    .bus_chip_selects_o(cs_o), .bus_chip_selects_oe(cs_oe), .bus_data_lines_i(d_i), .bus_data_lines_o(d_o),
    .bus_data_lines_oe(d_oe), .byte_lane_selects_i(be_i), .byte_lane_selects_o(be_o),
    .byte_lane_selects_oe(be_oe), .in_addr(in_addr), .in_wr_n(in_wr_n), .in_rd_n(in_rd_n));
  ebs_far_model far (.clk(lclk), .cs_o(cs_o), .cs_oe(cs_oe), .d_o(d_o), .d_oe(d_oe), .be_o(be_o), .be_oe(be_oe),
    .m_cs(m_cs), .m_den(m_den), .m_d(m_d), .m_be(m_be), .cs_i(cs_i), .d_i(d_i), .be_i(be_i));
  // Record what one outbound phase put on the pins
  always @(posedge lclk)
    if (cs_o != EBS_CS_IDLE)
    begin
      act_n++;
      {a_cs, a_be, a_dat, a_we} = {cs_o, be_o, d_o, d_oe};
    end
  task automatic summarize();
    if (failures == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  // One outbound request, checked against the expected pin phase
  task automatic do_req(input logic wr, input logic [2:0] cs, input ebs_mode_t md);
    logic [3:0] be;
    logic [31:0] wd;
    logic hp;
    int len;
    int i;
    be = 4'($urandom_range(1, 15));
    wd = $urandom;
    hp = (md == EBS_MODE_HOSTPORT) && (cs < EBS_HOSTPORT_MIN_CS);
    len = md == EBS_MODE_STROBE ? EBS_LEN_STROBE : md == EBS_MODE_BURST ? EBS_LEN_BURST :
      md == EBS_MODE_DSTROBE ? EBS_LEN_DSTROBE : md == EBS_MODE_NOTURN ? EBS_LEN_NOTURN : EBS_LEN_HOSTPORT;
    act_n = 0;
    @(posedge clk_sys);
    cs_mode[cs] <= md;
    req_valid <= 1'b1;
    req_in <= '{wr, cs, md, be, wd};
    do @(posedge clk_sys); while (!req_ready);
    req_valid <= 1'b0;
    for (i = 0; i < 300 && rsp_valid !== 1'b1; i++)
      @(posedge clk_sys);
    `CHK(rsp_valid, 1'b1)
    `CHK(rsp_err, hp)
    `CHK(act_n, hp ? 0 : len)
    if (!hp)
    begin
      `CHK(a_cs, ~(8'h01 << cs))
      `CHK(a_be, ~be)
      `CHK(a_we, wr)
      if (wr)
        `CHK(a_dat, wd)
      else
        `CHK(rsp_rdata, 32'h5A3C_0000 ^ {29'h0, cs})
    end
  endtask : do_req
  // Inbound write from the granted master
  task automatic in_write(input logic [3:0] a, input logic [3:0] be, input logic [31:0] d);
    @(posedge lclk);
    {in_addr, in_wr_n, m_be, m_d, m_den} <= {a, 1'b0, be, d, 1'b1};
    @(posedge lclk);
    {in_wr_n, m_den} <= 2'b10;
    for (int l = 0; l < 4; l++)
      if (!be[l])
        mem[a][8*l +: 8] = d[8*l +: 8];
  endtask : in_write
  // Inbound reads are whole words
  task automatic in_read(input logic [3:0] a);
    @(posedge lclk);
    {in_addr, in_rd_n} <= {a, 1'b0};
    repeat (4) @(posedge lclk);
    `CHK(d_oe, 1'b1)
    `CHK(d_o, mem[a])
    in_rd_n <= 1'b1;
  endtask : in_read
  initial
  begin
    void'($urandom(95));
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
    for (int m = 0; m < 5; m++)
      for (int c = 0; c < 8; c++)
        do_req(1'($urandom), 3'(c), ebs_mode_t'(m));
    `CHK(arb_cs_idle, 1'b1)
    @(posedge lclk);
    ext_grant <= 1'b1;
    repeat (4) @(posedge lclk);
    m_cs <= 8'h7F;
    for (int k = 0; k < 4; k++)
    begin
      in_write(4'(k), 4'h0, $urandom);
      in_write(4'(k), 4'($urandom), $urandom);
    end
    for (int k = 0; k < 4; k++)
      in_read(4'(k));
    `CHK(arb_cs_idle, 1'b0)
    // Let the last read word leave the pins before the grant goes
    repeat (2) @(posedge lclk);
    m_cs <= 8'hFF;
    ext_grant <= 1'b0;
    repeat (8) @(posedge clk_sys);
    do_req(1'b1, 3'h5, EBS_MODE_NOTURN);
    summarize();
  end
  // Tests take some 4 us; a hang is cut short well past that
  initial
  begin
    #50_000;
    failures++;
    summarize();
  end
endmodule : ebs_lanes_test
bind ebs_lanes ebs_lanes_asserts u_chk (.clk_sys(clk_sys), .rst_b(rst_b), .expansion_bus_clock(expansion_bus_clock),
  .cs_mode(cs_mode), .req_valid(req_valid), .req_in(req_in), .req_ready(req_ready), .rsp_valid(rsp_valid),
  .rsp_err(rsp_err), .ext_grant(ext_grant), .arb_cs_idle(arb_cs_idle), .bus_chip_selects_i(bus_chip_selects_i),
  .bus_chip_selects_o(bus_chip_selects_o), .bus_chip_selects_oe(bus_chip_selects_oe),
  .bus_data_lines_oe(bus_data_lines_oe), .byte_lane_selects_oe(byte_lane_selects_oe));
